/* rtl/phy_cfg_pkg.sv */
/*
 * Shared constants for the interface configuration register slice:
 * register indices, field positions, reset values, timing counts.
 * Assumes a 20 MHz system clock and a classic Wishbone master.
 */
package phy_cfg_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [6:0] IDX_RGMII_CONTROL        = 7'h32;
	localparam logic [6:0] IDX_RGMII_CONTROL_SECOND = 7'h33;
	localparam logic [6:0] IDX_NEGOTIATION_STATUS   = 7'h37;
	localparam logic [6:0] IDX_FAST_ETHERNET_CONFIG = 7'h43;
	localparam logic [6:0] IDX_EVENT_STATUS         = 7'h60;
	localparam logic [6:0] IDX_EVENT_CLEAR          = 7'h61;
	localparam logic [6:0] IDX_EVENT_ENABLE         = 7'h62;
	localparam logic [6:0] IDX_LINK_STATUS          = 7'h63;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int TX_CLK_SHIFT_BIT   = 1;
	localparam int RX_CLK_SHIFT_BIT   = 0;
	localparam int FIFO_BYPASS_BIT    = 4;
	localparam int BYPASS_DELAY_BIT   = 3;
	localparam int LOW_LATENCY_BIT    = 2;
	localparam int PAGE_RX_BIT        = 1;
	localparam int NEG_DONE_BIT       = 0;
	localparam int TIMEOUT_DIS_BIT    = 11;
	localparam int TIMEOUT_MS_LSB     = 7;
	localparam int FORCE_LINK_BIT     = 6;
	localparam int TERNARY_DET_BIT    = 5;
	localparam int GAP_DET_BIT        = 4;
	localparam int SCRAMBLER_DIS_BIT  = 2;
	localparam int ODD_NIBBLE_BIT     = 1;
	localparam int EARLY_RX_VALID_BIT = 0;

	// Event bits in status, clear and enable registers
	localparam int EV_PAGE_RX    = 0;
	localparam int EV_NEG_DONE   = 1;
	localparam int EV_RX_ABORT   = 2;
	localparam int EV_ODD_NIBBLE = 3;
	localparam int EV_COUNT      = 4;

	// ************************************************************
	// Reset values and writable masks
	// ************************************************************
	localparam logic [15:0] RGMII_CONTROL_MASK   = 16'h0003;
	localparam logic [15:0] RGMII_CONTROL_RESET  = 16'h0000;
	localparam logic [15:0] RGMII_SECOND_MASK    = 16'h001c;
	localparam logic [15:0] RGMII_SECOND_RESET   = 16'h0000;
	localparam logic [15:0] FAST_ETH_MASK        = 16'h0ff7;
	localparam logic [15:0] FAST_ETH_RESET       = 16'h07a0;
	localparam logic [3:0]  EVENT_ENABLE_RESET   = 4'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ            = 20000000;
	localparam int MS_PERIOD_US      = 1000;
	localparam int PACKET_LIMIT_US   = 1500;
	localparam int MS_CYCLES         = CLK_HZ / 1000000 * MS_PERIOD_US;
	localparam int PACKET_LIMIT_CYC  = CLK_HZ / 1000000 * PACKET_LIMIT_US;

	// Receive guard states, Gray coded along idle-run-stop-recover
	typedef enum logic [1:0]
	{
		GUARD_IDLE    = 2'b00,
		GUARD_RUN     = 2'b01,
		GUARD_STOP    = 2'b11,
		GUARD_RECOVER = 2'b10
	} guard_state_t;

endpackage

/* rtl/phy_mac_iface_config_regs.sv */
/*
 * Interface configuration and status register slice of a PHY,
 * reached over a classic Wishbone slave, with event interrupts,
 * a sampled link clock and the receive guard timer.
 * Assumes a 20 MHz clk_i, synchronous active-high reset and link
 * inputs asynchronous to clk_i, all passing a two-flop synchroniser.
 */
`timescale 1ns/10ps
module phy_mac_iface_config_regs #(
	parameter int MS_CYCLES    = phy_cfg_pkg::MS_CYCLES,
	parameter int LIMIT_CYCLES = phy_cfg_pkg::PACKET_LIMIT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [8:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Link side inputs, asynchronous
	input  wire logic        link_clk_i,
	input  wire logic        page_rx_i,
	input  wire logic        neg_done_i,
	input  wire logic        rx_active_i,
	input  wire logic        link_qualified_i,
	// Datapath controls
	output logic             tx_clk_shift_o,
	output logic             rx_clk_shift_o,
	output logic             async_fifo_bypass_en_o,
	output logic             bypass_rx_clock_delay_en_o,
	output logic             low_latency_en_o,
	output logic             scrambler_disable_o,
	output logic             enhanced_ternary_detect_en_o,
	output logic             enhanced_gap_detect_en_o,
	output logic             early_rx_valid_en_o,
	output logic             link_good_o,
	output logic             rx_stop_o,
	output logic             odd_frame_o,
	output logic             irq_o
);

	// ************************************************************
	// Input synchroniser and link clock edge
	// ************************************************************

	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic       lclk_prev_r;
	wire  [4:0] async_in = {link_qualified_i, rx_active_i, neg_done_i, page_rx_i, link_clk_i};

	// Two flops per input before anything looks at it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_r     <= 5'h00;
			sync2_r     <= 5'h00;
			lclk_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r     <= async_in;
			sync2_r     <= sync1_r;
			lclk_prev_r <= sync2_r[0];
		end
	end

	// Synchronised inputs and link clock rising edge
	wire lclk_s     = sync2_r[0];
	wire page_rx_s  = sync2_r[1];
	wire neg_done_s = sync2_r[2];
	wire rx_act_s   = sync2_r[3];
	wire qual_s     = sync2_r[4];
	wire lclk_rise  = lclk_s && !lclk_prev_r;

	// ************************************************************
	// Wishbone decode
	// ************************************************************

	// A held strobe is taken every other cycle: no request while ack is out
	logic        ack_r;
	logic [31:0] rdata_r;
	wire  [6:0]  idx     = wb_adr_i[8:2];
	wire         req     = wb_cyc_i && wb_stb_i && !ack_r;
	wire         wr      = req && wb_we_i;
	// One select per mapped register
	wire         sel_ctl = (idx == phy_cfg_pkg::IDX_RGMII_CONTROL);
	wire         sel_ct2 = (idx == phy_cfg_pkg::IDX_RGMII_CONTROL_SECOND);
	wire         sel_neg = (idx == phy_cfg_pkg::IDX_NEGOTIATION_STATUS);
	wire         sel_fec = (idx == phy_cfg_pkg::IDX_FAST_ETHERNET_CONFIG);
	wire         sel_evs = (idx == phy_cfg_pkg::IDX_EVENT_STATUS);
	wire         sel_evc = (idx == phy_cfg_pkg::IDX_EVENT_CLEAR);
	wire         sel_eve = (idx == phy_cfg_pkg::IDX_EVENT_ENABLE);
	wire         sel_lnk = (idx == phy_cfg_pkg::IDX_LINK_STATUS);

	// Byte lanes to bit mask over the 16 implemented data bits
	wire  [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ************************************************************
	// Configuration registers
	// ************************************************************

	logic [15:0] ctl_r;
	logic [15:0] ct2_r;
	logic [15:0] fec_r;
	logic [3:0]  ev_en_r;

	// Merge writes through lane and writable masks, reserved bits stay 0
	wire  [15:0] ctl_wm  = lane_mask & phy_cfg_pkg::RGMII_CONTROL_MASK;
	wire  [15:0] ct2_wm  = lane_mask & phy_cfg_pkg::RGMII_SECOND_MASK;
	wire  [15:0] fec_wm  = lane_mask & phy_cfg_pkg::FAST_ETH_MASK;
	wire  [15:0] ctl_nxt = (ctl_r & ~ctl_wm) | (wb_dat_i[15:0] & ctl_wm);
	wire  [15:0] ct2_nxt = (ct2_r & ~ct2_wm) | (wb_dat_i[15:0] & ct2_wm);
	wire  [15:0] fec_nxt = (fec_r & ~fec_wm) | (wb_dat_i[15:0] & fec_wm);
	wire  [3:0]  ev_en_nxt = wb_sel_i[0] ? wb_dat_i[3:0] : ev_en_r;

	// Software writes to the configuration registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl_r   <= phy_cfg_pkg::RGMII_CONTROL_RESET;
			ct2_r   <= phy_cfg_pkg::RGMII_SECOND_RESET;
			fec_r   <= phy_cfg_pkg::FAST_ETH_RESET;
			ev_en_r <= phy_cfg_pkg::EVENT_ENABLE_RESET;
		end
		else
		begin
			if (wr && sel_ctl)
				ctl_r <= ctl_nxt;
			if (wr && sel_ct2)
				ct2_r <= ct2_nxt;
			if (wr && sel_fec)
				fec_r <= fec_nxt;
			if (wr && sel_eve)
				ev_en_r <= ev_en_nxt;
		end
	end

	// ************************************************************
	// Negotiation status
	// ************************************************************

	logic page_seen_r;
	logic neg_done_r;

	// Page flag holds once a page arrives; done follows the link
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			page_seen_r <= 1'b0;
			neg_done_r  <= 1'b0;
		end
		else
		begin
			page_seen_r <= page_seen_r | page_rx_s;
			neg_done_r  <= neg_done_s;
		end
	end

	// Reserved bits of the status word read zero
	wire [15:0] neg_word = {14'h0000, page_seen_r, neg_done_r};

	// ************************************************************
	// Odd nibble detection on link clock edges
	// ************************************************************

	logic frame_r;
	logic parity_r;
	logic odd_r;
	logic odd_ev_r;
	wire  odd_en      = fec_r[phy_cfg_pkg::ODD_NIBBLE_BIT];
	wire  nibble      = lclk_rise && rx_act_s;
	wire  frame_start = nibble && !frame_r;
	// No link edge needed at the end: the link clock stops between frames
	wire  frame_end   = frame_r && !rx_act_s;

	// Nibble parity per frame, judged when the frame ends
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			frame_r  <= 1'b0;
			parity_r <= 1'b0;
			odd_r    <= 1'b0;
			odd_ev_r <= 1'b0;
		end
		else
		begin
			odd_ev_r <= 1'b0;
			if (nibble)
			begin
				frame_r  <= 1'b1;
				parity_r <= parity_r ^ 1'b1;
			end
			else if (frame_end)
			begin
				frame_r  <= 1'b0;
				parity_r <= 1'b0;
			end
			if (frame_start)
				odd_r <= 1'b0;
			if (frame_end && odd_en && parity_r)
			begin
				odd_r    <= 1'b1;
				odd_ev_r <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Receive guard timer
	// ************************************************************

	logic guard_stop;
	logic guard_abort;

	rx_guard_timer #(
		.MS_CYCLES    (MS_CYCLES),
		.LIMIT_CYCLES (LIMIT_CYCLES)
	) u_guard (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.rx_active_i       (rx_act_s),
		.timeout_disable_i (fec_r[phy_cfg_pkg::TIMEOUT_DIS_BIT]),
		.recovery_ms_i     (fec_r[phy_cfg_pkg::TIMEOUT_MS_LSB +: 4]),
		.stop_o            (guard_stop),
		.abort_o           (guard_abort)
	);

	// ************************************************************
	// Events and interrupt
	// ************************************************************

	logic [3:0] ev_sts_r;
	logic       page_prev_r;
	logic       done_prev_r;
	wire  [3:0] ev_set;
	wire  [3:0] ev_clr = (wr && sel_evc && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

	// Event sources, one rising edge or pulse each
	assign ev_set[phy_cfg_pkg::EV_PAGE_RX]    = page_rx_s && !page_prev_r;
	assign ev_set[phy_cfg_pkg::EV_NEG_DONE]   = neg_done_s && !done_prev_r;
	assign ev_set[phy_cfg_pkg::EV_RX_ABORT]   = guard_abort;
	assign ev_set[phy_cfg_pkg::EV_ODD_NIBBLE] = odd_ev_r;

	// Sticky status, a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_sts_r    <= 4'h0;
			page_prev_r <= 1'b0;
			done_prev_r <= 1'b0;
			irq_o       <= 1'b0;
		end
		else
		begin
			page_prev_r <= page_rx_s;
			done_prev_r <= neg_done_s;
			ev_sts_r    <= (ev_sts_r & ~ev_clr) | ev_set;
			irq_o       <= |(((ev_sts_r & ~ev_clr) | ev_set) & ev_en_r);
		end
	end

	// ************************************************************
	// Read multiplexer and acknowledge
	// ************************************************************

	// Link status word and read selection
	wire [15:0] lnk_word  = {12'h000, odd_r, guard_stop, qual_s, link_good_o};
	wire [15:0] read_word = sel_ctl ? ctl_r :
	                        sel_ct2 ? ct2_r :
	                        sel_neg ? neg_word :
	                        sel_fec ? fec_r :
	                        sel_evs ? {12'h000, ev_sts_r} :
	                        sel_eve ? {12'h000, ev_en_r} :
	                        sel_lnk ? lnk_word : 16'h0000;

	// One wait state: ack one cycle after the request, then drop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end
		else
		begin
			ack_r   <= req;
			rdata_r <= req ? {16'h0000, read_word} : 32'h00000000;
		end
	end

	// Bus outputs straight from their flops
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ************************************************************
	// Datapath control outputs
	// ************************************************************

	// Every control leaves through its own flop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_clk_shift_o               <= 1'b0;
			rx_clk_shift_o               <= 1'b0;
			async_fifo_bypass_en_o       <= 1'b0;
			bypass_rx_clock_delay_en_o   <= 1'b0;
			low_latency_en_o             <= 1'b0;
			scrambler_disable_o          <= 1'b0;
			enhanced_ternary_detect_en_o <= 1'b1;
			enhanced_gap_detect_en_o     <= 1'b0;
			early_rx_valid_en_o          <= 1'b0;
			link_good_o                  <= 1'b0;
			rx_stop_o                    <= 1'b0;
			odd_frame_o                  <= 1'b0;
		end
		else
		begin
			tx_clk_shift_o               <= ctl_r[phy_cfg_pkg::TX_CLK_SHIFT_BIT];
			rx_clk_shift_o               <= ctl_r[phy_cfg_pkg::RX_CLK_SHIFT_BIT];
			async_fifo_bypass_en_o       <= ct2_r[phy_cfg_pkg::FIFO_BYPASS_BIT];
			bypass_rx_clock_delay_en_o   <= ct2_r[phy_cfg_pkg::BYPASS_DELAY_BIT];
			low_latency_en_o             <= ct2_r[phy_cfg_pkg::LOW_LATENCY_BIT];
			scrambler_disable_o          <= fec_r[phy_cfg_pkg::SCRAMBLER_DIS_BIT];
			enhanced_ternary_detect_en_o <= fec_r[phy_cfg_pkg::TERNARY_DET_BIT];
			enhanced_gap_detect_en_o     <= fec_r[phy_cfg_pkg::GAP_DET_BIT];
			early_rx_valid_en_o          <= fec_r[phy_cfg_pkg::EARLY_RX_VALID_BIT];
			link_good_o                  <= fec_r[phy_cfg_pkg::FORCE_LINK_BIT] | qual_s;
			rx_stop_o                    <= guard_stop;
			odd_frame_o                  <= odd_r;
		end
	end

endmodule

/* rtl/rx_guard_timer.sv */
/*
 * Receive guard: stops an overlong packet and holds reception off
 * for a programmable recovery time in milliseconds afterwards.
 * Assumes rx_active_i is already synchronous to clk_i.
 */
`timescale 1ns/10ps
module rx_guard_timer #(
	parameter int MS_CYCLES    = phy_cfg_pkg::MS_CYCLES,
	parameter int LIMIT_CYCLES = phy_cfg_pkg::PACKET_LIMIT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       rx_active_i,
	input  wire logic       timeout_disable_i,
	input  wire logic [3:0] recovery_ms_i,
	output logic            stop_o,
	output logic            abort_o
);
	phy_cfg_pkg::guard_state_t state_r;
	phy_cfg_pkg::guard_state_t state_nxt;
	logic [15:0] ms_cnt_r;
	logic [15:0] pkt_cnt_r;
	logic [3:0]  rec_cnt_r;
	wire         ms_tick   = (ms_cnt_r == 16'(MS_CYCLES - 1));
	wire         too_long  = (pkt_cnt_r == 16'(LIMIT_CYCLES - 1)) && !timeout_disable_i;

	// Next state of the guard
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			phy_cfg_pkg::GUARD_IDLE:    if (rx_active_i) state_nxt = phy_cfg_pkg::GUARD_RUN;
			phy_cfg_pkg::GUARD_RUN:     if (!rx_active_i) state_nxt = phy_cfg_pkg::GUARD_IDLE;
			                            else if (too_long) state_nxt = phy_cfg_pkg::GUARD_STOP;
			phy_cfg_pkg::GUARD_STOP:    if (!rx_active_i) state_nxt = phy_cfg_pkg::GUARD_RECOVER;
			phy_cfg_pkg::GUARD_RECOVER: if (rec_cnt_r == 4'h0) state_nxt = phy_cfg_pkg::GUARD_IDLE;
		endcase
	end

	// Millisecond prescaler, packet length and recovery counters
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r   <= phy_cfg_pkg::GUARD_IDLE;
			ms_cnt_r  <= 16'h0000;
			pkt_cnt_r <= 16'h0000;
			rec_cnt_r <= 4'h0;
			stop_o    <= 1'b0;
			abort_o   <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			ms_cnt_r  <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
			pkt_cnt_r <= (state_r == phy_cfg_pkg::GUARD_RUN) ? pkt_cnt_r + 16'h0001 : 16'h0000;
			if (state_nxt == phy_cfg_pkg::GUARD_RECOVER && state_r == phy_cfg_pkg::GUARD_STOP)
				rec_cnt_r <= recovery_ms_i;
			else if (ms_tick && rec_cnt_r != 4'h0)
				rec_cnt_r <= rec_cnt_r - 4'h1;
			stop_o    <= (state_nxt == phy_cfg_pkg::GUARD_STOP) ||
			             (state_nxt == phy_cfg_pkg::GUARD_RECOVER);
			abort_o   <= (state_r == phy_cfg_pkg::GUARD_RUN) && (state_nxt == phy_cfg_pkg::GUARD_STOP);
		end
	end
endmodule

/* verification/link_partner_model.sv */
/* Link-side model: frames of whole nibbles, link clock in frames only.
   Assumes go_i rises once per frame, from the bench. */
`timescale 1ns/10ps
module link_partner_model (
	input  wire logic       go_i,
	input  wire logic [7:0] len_i,
	output logic            link_clk_o,
	output logic            rx_active_o
);
	// ****************
	// Frame generator
	// ****************
	// Idle: clock stands low; one frame per rising go_i, 400 ns period
	initial
	begin
		link_clk_o = 1'b0;
		rx_active_o = 1'b0;
		forever
		begin
			@(posedge go_i);
			#5 rx_active_o = 1'b1;
			repeat (len_i)
			begin
				#137 link_clk_o = 1'b1;
				#200 link_clk_o = 1'b0;
				#63;
			end
			#130 rx_active_o = 1'b0;
		end
	end
endmodule

/* verification/phy_mac_iface_config_regs_assertions.sv */
/* Port checker for the register slice, bound into the design.
   Assumes a one-cycle registered ack and registered controls. */
`timescale 1ns/10ps
module cfg_regs_checker #(
	parameter int MS_CYCLES    = 20,
	parameter int LIMIT_CYCLES = 30
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [8:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rx_active_i,
	input wire logic        tx_clk_shift_o,
	input wire logic        rx_clk_shift_o,
	input wire logic        async_fifo_bypass_en_o,
	input wire logic        bypass_rx_clock_delay_en_o,
	input wire logic        low_latency_en_o,
	input wire logic        scrambler_disable_o,
	input wire logic        enhanced_ternary_detect_en_o,
	input wire logic        enhanced_gap_detect_en_o,
	input wire logic        early_rx_valid_en_o,
	input wire logic        rx_stop_o,
	input wire logic        irq_o
);
	// ****************
	// Helpers
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Write taken with the low byte lane enabled
	wire        wr_w = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
	wire [6:0]  idx_w = wb_adr_i[8:2];
	logic [15:0] act_cnt_r;
	// Cycles of unbroken packet activity, saturating
	always_ff @(posedge clk_i)
		act_cnt_r <= (rst_i | ~rx_active_i) ? 16'h0 : act_cnt_r + {15'h0, ~&act_cnt_r};
	// ****************
	// Properties
	// ****************
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_upper0; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
	property p_ctl;
		wr_w && idx_w == 7'h32 |=> ##1
			{tx_clk_shift_o, rx_clk_shift_o} == $past(wb_dat_i[1:0], 2);
	endproperty
	property p_second;
		wr_w && idx_w == 7'h33 |=> ##1 {async_fifo_bypass_en_o,
			bypass_rx_clock_delay_en_o, low_latency_en_o} == $past(wb_dat_i[4:2], 2);
	endproperty
	property p_config;
		wr_w && idx_w == 7'h43 |=> ##1 {enhanced_ternary_detect_en_o,
			enhanced_gap_detect_en_o, scrambler_disable_o, early_rx_valid_en_o}
			== $past({wb_dat_i[5:4], wb_dat_i[2], wb_dat_i[0]}, 2);
	endproperty
	property p_stop; $rose(rx_stop_o) |-> act_cnt_r >= LIMIT_CYCLES; endproperty
	property p_reset;
		$fell(rst_i) |-> !wb_ack_o && !irq_o && !rx_stop_o && enhanced_ternary_detect_en_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero while idle");
	a_upper0: assert property (p_upper0) else $error("upper read half not zero");
	a_ctl: assert property (p_ctl) else $error("clock shift controls wrong");
	a_second: assert property (p_second) else $error("second controls wrong");
	a_config: assert property (p_config) else $error("config controls wrong");
	a_stop: assert property (p_stop) else $error("packet stopped too early");
	a_reset: assert property (p_reset) else $error("bad outputs after reset");
	c_config: cover property (wr_w && idx_w == 7'h43);
	c_stop: cover property ($rose(rx_stop_o));
	c_irq: cover property ($rose(irq_o));
endmodule
bind phy_mac_iface_config_regs cfg_regs_checker #(.MS_CYCLES(MS_CYCLES),
	.LIMIT_CYCLES(LIMIT_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rx_active_i(rx_active_i), .tx_clk_shift_o(tx_clk_shift_o),
	.rx_clk_shift_o(rx_clk_shift_o), .async_fifo_bypass_en_o(async_fifo_bypass_en_o),
	.bypass_rx_clock_delay_en_o(bypass_rx_clock_delay_en_o),
	.low_latency_en_o(low_latency_en_o), .scrambler_disable_o(scrambler_disable_o),
	.enhanced_ternary_detect_en_o(enhanced_ternary_detect_en_o),
	.enhanced_gap_detect_en_o(enhanced_gap_detect_en_o),
	.early_rx_valid_en_o(early_rx_valid_en_o), .rx_stop_o(rx_stop_o), .irq_o(irq_o));

/* verification/phy_mac_iface_config_regs_tb_top.sv */
/* Bench top: Wishbone master tasks, link partner, random register
   traffic, events, frames and guard. Assumes the checker is bound. */
`timescale 1ns/10ps
module phy_mac_iface_config_regs_tb_top;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go;
	logic [8:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        link_clk_i, page_rx_i, neg_done_i, rx_active_i, link_qualified_i;
	logic        tx_clk_shift_o, rx_clk_shift_o, async_fifo_bypass_en_o, low_latency_en_o;
	logic        bypass_rx_clock_delay_en_o, scrambler_disable_o, enhanced_gap_detect_en_o;
	logic        enhanced_ternary_detect_en_o, early_rx_valid_en_o, link_good_o;
	logic        rx_stop_o, odd_frame_o, irq_o;
	logic [7:0]  nib_len;
	logic [15:0] sh [0:127];
	logic [6:0]  ids [5] = '{7'h32, 7'h33, 7'h37, 7'h43, 7'h62};
	int          n_mismatch, checks, seed;
	// Control outputs in one word
	wire  [8:0]  ctl_w = {tx_clk_shift_o, rx_clk_shift_o, async_fifo_bypass_en_o,
		bypass_rx_clock_delay_en_o, low_latency_en_o, scrambler_disable_o,
		enhanced_ternary_detect_en_o, enhanced_gap_detect_en_o, early_rx_valid_en_o};
	phy_mac_iface_config_regs #(.MS_CYCLES(20), .LIMIT_CYCLES(30)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i), .page_rx_i(page_rx_i),
		.neg_done_i(neg_done_i), .rx_active_i(rx_active_i),
		.link_qualified_i(link_qualified_i), .tx_clk_shift_o(tx_clk_shift_o),
		.rx_clk_shift_o(rx_clk_shift_o), .async_fifo_bypass_en_o(async_fifo_bypass_en_o),
		.bypass_rx_clock_delay_en_o(bypass_rx_clock_delay_en_o),
		.low_latency_en_o(low_latency_en_o), .scrambler_disable_o(scrambler_disable_o),
		.enhanced_ternary_detect_en_o(enhanced_ternary_detect_en_o),
		.enhanced_gap_detect_en_o(enhanced_gap_detect_en_o),
		.early_rx_valid_en_o(early_rx_valid_en_o), .link_good_o(link_good_o),
		.rx_stop_o(rx_stop_o), .odd_frame_o(odd_frame_o), .irq_o(irq_o));
	link_partner_model partner (.go_i(go), .len_i(nib_len), .link_clk_o(link_clk_i),
		.rx_active_o(rx_active_i));
	// ****************
	// Tasks
	// ****************
	// Writable bits per register
	function automatic logic [15:0] msk(input logic [6:0] idx);
		case (idx)
			7'h32: return 16'h0003;
			7'h33: return 16'h001c;
			7'h43: return 16'h0ff7;
			7'h62: return 16'h000f;
			default: return 16'h0000;
		endcase
	endfunction
	// Expected control outputs from the shadow registers
	function automatic logic [8:0] ctl_exp();
		return {sh[7'h32][1:0], sh[7'h33][4:2], sh[7'h43][2], sh[7'h43][5:4], sh[7'h43][0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic Wishbone cycle
	task automatic wb(input logic w, input logic [6:0] idx, input logic [3:0] s,
		input logic [15:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'h0};
		wb_sel_i <= s;
		wb_dat_i <= {~d, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 16)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 16) n_mismatch++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [6:0] idx, input logic [3:0] s, input logic [15:0] d);
		logic [31:0] q;
		logic [15:0] m;
		m = msk(idx) & {{8{s[1]}}, {8{s[0]}}};
		wb(1'b1, idx, s, d, q);
		sh[idx] = (sh[idx] & ~m) | (d & m);
	endtask
	task automatic rd_chk(input logic [6:0] idx, input logic [15:0] e);
		logic [31:0] q;
		wb(1'b0, idx, 4'hf, 16'h0, q);
		check(q, {16'h0, e});
	endtask
	// One partner frame of len nibbles, then time for the synchronisers
	task automatic frame(input int len);
		int n;
		n = 0;
		nib_len <= len[7:0];
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		while (rx_active_i !== 1'b0 && n < 400)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 400) n_mismatch++;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	// 20 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		end_sim;
	end
	// Main scenarios
	initial
	begin
		logic [6:0] idx;
		int         n;
		{wb_cyc_i, wb_stb_i, wb_we_i, go, page_rx_i, neg_done_i, link_qualified_i} = 7'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, nib_len} = 53'h0;
		seed = 32'h46fc0f8f;
		n_mismatch = 0;
		checks = 0;
		foreach (sh[i]) sh[i] = 16'h0000;
		sh[7'h43] = 16'h07a0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'(ctl_w), 32'(ctl_exp()));
		foreach (ids[i]) rd_chk(ids[i], sh[ids[i]]);
		wr(7'h43, 4'h3, 16'hffff);
		rd_chk(7'h43, 16'h0ff7);
		wr(7'h10, 4'h3, 16'hffff);
		rd_chk(7'h10, 16'h0000);
		repeat (40)
		begin
			idx = ids[$unsigned($random(seed)) % 4];
			wr(idx, 4'($random(seed)), 16'($random(seed)));
			rd_chk(idx, sh[idx]);
			check(32'(ctl_w), 32'(ctl_exp()));
		end
		wr(7'h62, 4'h3, 16'h000f);
		page_rx_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		page_rx_i <= 1'b0;
		neg_done_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check(32'(irq_o), 32'h1);
		rd_chk(7'h37, 16'h0003);
		rd_chk(7'h60, 16'h0003);
		wr(7'h61, 4'h3, 16'h0003);
		rd_chk(7'h61, 16'h0000);
		rd_chk(7'h60, 16'h0000);
		check(32'(irq_o), 32'h0);
		neg_done_i <= 1'b0;
		wr(7'h62, 4'h3, 16'h0000);
		wr(7'h43, 4'h3, 16'h0182);
		frame(3);
		check(32'(odd_frame_o), 32'h1);
		rd_chk(7'h37, 16'h0002);
		check(32'(irq_o), 32'h0);
		wr(7'h62, 4'h3, 16'h000f);
		check(32'(irq_o), 32'h1);
		frame(2);
		check(32'(odd_frame_o), 32'h0);
		wr(7'h61, 4'h3, 16'h000f);
		wr(7'h43, 4'h3, 16'h0180);
		frame(3);
		check(32'(odd_frame_o), 32'h0);
		rd_chk(7'h60, 16'h0000);
		frame(10);
		check(32'(rx_stop_o), 32'h1);
		rd_chk(7'h60, 16'h0004);
		n = 0;
		while (rx_stop_o === 1'b1 && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		check(32'(n >= 25 && n <= 56), 32'h1);
		wr(7'h43, 4'h3, 16'h0980);
		frame(10);
		check(32'(rx_stop_o), 32'h0);
		wr(7'h43, 4'h3, 16'h09c0);
		check(32'(link_good_o), 32'h1);
		wr(7'h43, 4'h3, 16'h0980);
		check(32'(link_good_o), 32'h0);
		link_qualified_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check(32'(link_good_o), 32'h1);
		rd_chk(7'h63, 16'h0003);
		end_sim;
	end
endmodule
